//--- pkg/threshold_monitor_params.svh
// Purpose: Offsets, reset values and timing counts of the threshold monitor.
// Assumes: 50 MHz hclk. Signed values are in tenths of a unit.
// Notes: Included by the burst sampler, the monitor and the testbench.
`ifndef THRESHOLD_MONITOR_PARAMS_SVH
`define THRESHOLD_MONITOR_PARAMS_SVH
`define OFS_CUR_A       12'h000
`define OFS_CUR_B       12'h004
`define OFS_VOLT_A      12'h008
`define OFS_VOLT_B      12'h00c
`define OFS_IN_LOW      12'h010
`define OFS_IN_LIM      12'h014
`define OFS_OUT_LIM     12'h018
`define OFS_BURST_CFG   12'h01c
`define OFS_CTRL        12'h020
`define OFS_MASK        12'h024
`define OFS_STATUS      12'h028
`define OFS_POWER       12'h02c
`define OFS_TEMP        12'h030
`define OFS_ERR         12'h034
`define CUR_MIN         16'sd100
`define CUR_MAX         16'sd600
`define CUR_A_LOW_RST   16'sd250
`define CUR_A_HIGH_RST  16'sd500
`define CUR_B_LOW_RST   16'sd100
`define CUR_B_HIGH_RST  16'sd500
`define VOLT_MIN        16'sd100
`define VOLT_MAX        16'sd250
`define VOLT_HIGH_RST   16'sd240
`define VOLT_LOW_RST    16'sd150
`define RXIN_MIN        -16'sd400
`define RXIN_MAX        16'sd50
`define RXIN_A_RST      -16'sd400
`define RXIN_B_RST      16'sd0
`define TXIN_MIN        -16'sd600
`define TXIN_MAX        -16'sd150
`define TXIN_HIGH_RST   -16'sd150
`define TXIN_LOW_RST    -16'sd600
`define RATED_SPAN      16'sd200
`define OUT_HIGH_RST    16'sd340
`define OUT_LOW_RST     16'sd130
`define BURST_LVL_RST   16'sd130
`define BURST_N_RST     5'd8
`define BURST_N_MAX     5'd16
`define MASK_RST        16'h0078
`define CTRL_RST        16'h0040
`define CTRL_MASK       16'h03ff
`define TEMP_MIN        -16'sd50
`define TEMP_MAX        16'sd100
`define CLK_MHZ         50
`define SAMPLE_US       125
`define SAMPLE_CYC      (`SAMPLE_US * `CLK_MHZ)
`endif

//--- pkg/threshold_monitor_pkg.sv
// Purpose: Types shared by the threshold monitor files.
// Assumes: Nothing beyond the parameter header.
// Notes: Holds types only.
package threshold_monitor_pkg;
   typedef struct packed {
      logic signed [15:0] high;
      logic signed [15:0] low;
   } limit_pair_t;
   typedef struct packed {
      logic [1:0]  htrans;
      logic        hwrite;
      logic [11:0] haddr;
   } ahb_addr_t;
   typedef enum logic [2:0] {
      BURST_IDLE   = 3'b001,
      BURST_SAMPLE = 3'b010,
      BURST_SORT   = 3'b100
   } burst_state_t;
endpackage

//--- verilog/limit_check.sv
// Purpose: Range and ordering check of a threshold pair write.
// Assumes: Values in tenths, signed.
// Notes: Pure combinational.
`timescale 1ns/1ps
module limit_check import threshold_monitor_pkg::*; (
   input  wire limit_pair_t        pair,
   input  wire logic signed [15:0] min_v,
   input  wire logic signed [15:0] max_v,
   output wire logic               ok
);
   // Both in range and low strictly below high.
   assign ok = (pair.low >= min_v) && (pair.high <= max_v) && (pair.low < pair.high)
               && (pair.high >= min_v) && (pair.low <= max_v);
endmodule // limit_check

//--- verilog/burst_sampler.sv
// Purpose: Burst sampling, ordering and top-N averaging.
// Assumes: Power samples in tenths of dBm.
// Notes: Sort is one insertion per sample, so no pass is needed at the end.
`timescale 1ns/1ps
`include "threshold_monitor_params.svh"
module burst_sampler import threshold_monitor_pkg::*; (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               enable,
   input  wire logic signed [15:0] power_in,
   input  wire logic signed [15:0] valid_level,
   input  wire logic [4:0]         avg_count,
   output logic signed [15:0]      reading_ff,
   output logic                    done_ff
);
   localparam int unsigned SAMPLE_CYC = `SAMPLE_CYC;
   burst_state_t        state_ff;
   logic [12:0]         tick_ff;
   logic [4:0]          cnt_ff;
   logic [4:0]          idx_ff;
   logic signed [15:0]  slot_ff [16];
   logic signed [20:0]  sum_ff;
   wire                 tick_hit = (tick_ff == 13'(SAMPLE_CYC - 1));
   wire                 burst_seen = enable && (power_in >= valid_level);
   wire signed [20:0]   quot = sum_ff / $signed({16'h0000, avg_count});
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= BURST_IDLE;
         tick_ff <= 13'h0000;
         cnt_ff <= 5'h00;
         idx_ff <= 5'h00;
         sum_ff <= 21'h000000;
         reading_ff <= 16'h0000;
         done_ff <= 1'b0;
         for (int i = 0; i < 16; i++) begin
            slot_ff[i] <= 16'h8000;
         end
      end else begin
         done_ff <= 1'b0;
         case (state_ff)
            BURST_IDLE: begin
               // R15 Valid burst gate
               if (burst_seen) begin
                  state_ff <= BURST_SAMPLE;
                  tick_ff <= 13'h0000;
                  cnt_ff <= 5'h00;
                  for (int i = 0; i < 16; i++) begin
                     slot_ff[i] <= 16'h8000;
                  end
               end
            end
            BURST_SAMPLE: begin
               tick_ff <= tick_hit ? 13'h0000 : tick_ff + 13'h0001;
               // R13 Sample every period
               if (tick_hit) begin
                  // R14 Keep descending order
                  for (int i = 15; i > 0; i--) begin
                     if (power_in > slot_ff[i - 1]) begin
                        slot_ff[i] <= slot_ff[i - 1];
                     end else if (power_in > slot_ff[i]) begin
                        slot_ff[i] <= power_in;
                     end
                  end
                  if (power_in > slot_ff[0]) begin
                     slot_ff[0] <= power_in;
                  end
                  cnt_ff <= cnt_ff + 5'h01;
                  if (cnt_ff == 5'd15) begin
                     state_ff <= BURST_SORT;
                     idx_ff <= 5'h00;
                     sum_ff <= 21'h000000;
                  end
               end
            end
            BURST_SORT: begin
               // R14 Average largest N
               if (idx_ff < avg_count) begin
                  sum_ff <= sum_ff + 21'(slot_ff[idx_ff[3:0]]);
                  idx_ff <= idx_ff + 5'h01;
               end else begin
                  reading_ff <= quot[15:0];
                  done_ff <= 1'b1;
                  state_ff <= BURST_IDLE;
               end
            end
            default: state_ff <= BURST_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   AST_SIXTEEN_SAMPLES: assert property (@(posedge hclk) disable iff (!hresetn) // R13
      (state_ff == BURST_SAMPLE && tick_hit && cnt_ff == 5'd15) |=> (state_ff == BURST_SORT))
      else $error("Burst did not close after sixteen samples.");
   AST_ORDERED: assert property (@(posedge hclk) disable iff (!hresetn) // R14
      (state_ff == BURST_SORT) |-> (slot_ff[0] >= slot_ff[1] && slot_ff[1] >= slot_ff[2]))
      else $error("Samples not in descending order.");
   AST_BURST_GATE: assert property (@(posedge hclk) disable iff (!hresetn) // R15
      (state_ff == BURST_IDLE && !burst_seen) |=> (state_ff != BURST_SAMPLE))
      else $error("Burst started below valid level.");
endmodule // burst_sampler

//--- verilog/alarm_threshold_burst_monitor.sv
// Purpose: Threshold, alarm and burst power settings with AHB-Lite access.
// Assumes: Values are signed tenths; the bus master sends whole-word single transfers.
// Notes: Rejected writes keep the old value and set the error register.
// Summary of operation
// R1 - Side A low current, default 250
// R2 - Current low must stay below high
// R3 - Side B high current, default 500
// R4 - Input low limits 5.0 to -40.0
// R5 - Rx simulation faults relay, sets alarm
// R6 - Suppression masks alarms from major
// R7 - Side A volt limits 24 and 15
// R8 - Protocol select: ASCII or legacy binary
// R9 - Lamp dark when lamp enable zero
// R10 - Output limits ordered, within rated span
// R11 - Tx simulation raises Tx alarm
// R12 - Input limits -15 to -60, ordered
// R13 - Sample every 125 us, sixteen
// R14 - Sort, average largest N samples
// R15 - Burst valid at burst level
// R16 - Temperature reported -50 to +100
// R17 - Mains correction only on AC units
// R18 - Mode zero continuous, one burst
// R19 - Suppression mask default 0x0078
// R20 - Bad writes rejected, old value kept
`timescale 1ns/1ps
`include "threshold_monitor_params.svh"
module alarm_threshold_burst_monitor import threshold_monitor_pkg::*; (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [11:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic [31:0]             hrdata,
   output wire logic               hreadyout,
   output wire logic               hresp,
   input  wire logic               ac_powered,
   input  wire logic signed [15:0] output_power,
   input  wire logic signed [15:0] temperature,
   input  wire logic [15:0]        alarm_sources,
   output logic                    side_a_relay_fault,
   output logic                    side_b_relay_fault,
   output logic                    major_alarm,
   output logic                    lamp_drive,
   output logic                    link_protocol_select,
   output logic                    mains_scaling_correction,
   output logic [7:0]              alarm_byte
);
   ahb_addr_t          aph_ff;
   limit_pair_t        cur_a_ff;
   limit_pair_t        cur_b_ff;
   limit_pair_t        volt_a_ff;
   limit_pair_t        volt_b_ff;
   limit_pair_t        in_low_ff;
   limit_pair_t        in_lim_ff;
   limit_pair_t        out_lim_ff;
   logic signed [15:0] burst_lvl_ff;
   logic [4:0]         burst_n_ff;
   logic [15:0]        ctrl_ff;
   logic [15:0]        suppression_mask_ff;
   logic signed [15:0] power_ff;
   logic signed [15:0] temp_ff;
   logic [3:0]         err_ff;
   logic signed [15:0] burst_reading;
   logic               burst_done;
   logic               ok_cur;
   logic               ok_volt;
   logic               ok_in;
   logic               ok_out;
   ////////////////////////////////////////////////////////////////////////
   // Control bit positions.
   wire side_a_rx_alarm_simulate = ctrl_ff[0];
   wire side_b_rx_alarm_simulate = ctrl_ff[1];
   wire side_a_rx_suppress       = ctrl_ff[2];
   wire side_b_rx_suppress       = ctrl_ff[3];
   wire tx_alarm_simulate        = ctrl_ff[4];
   wire tx_power_suppress        = ctrl_ff[5];
   wire lamp_enable              = ctrl_ff[6];
   wire power_monitor_mode       = ctrl_ff[8];
   wire wr_phase   = aph_ff.htrans[1] && aph_ff.hwrite;
   wire limit_pair_t wpair = limit_pair_t'(hwdata);
   wire sel_cur_a  = wr_phase && (aph_ff.haddr == `OFS_CUR_A);
   wire sel_cur_b  = wr_phase && (aph_ff.haddr == `OFS_CUR_B);
   wire sel_volt_a = wr_phase && (aph_ff.haddr == `OFS_VOLT_A);
   wire sel_volt_b = wr_phase && (aph_ff.haddr == `OFS_VOLT_B);
   wire sel_in_low = wr_phase && (aph_ff.haddr == `OFS_IN_LOW);
   wire sel_in_lim = wr_phase && (aph_ff.haddr == `OFS_IN_LIM);
   wire sel_out    = wr_phase && (aph_ff.haddr == `OFS_OUT_LIM);
   wire sel_burst  = wr_phase && (aph_ff.haddr == `OFS_BURST_CFG);
   wire sel_ctrl   = wr_phase && (aph_ff.haddr == `OFS_CTRL);
   wire sel_mask   = wr_phase && (aph_ff.haddr == `OFS_MASK);
   wire signed [15:0] out_floor = out_lim_ff.high - `RATED_SPAN;
   wire [4:0] wr_n  = hwdata[20:16];
   wire signed [15:0] wr_lvl = hwdata[15:0];
   // R10 Output span check
   wire ok_burst = (wr_n >= 5'd1) && (wr_n <= `BURST_N_MAX) && (wr_lvl <= out_lim_ff.high)
                   && (wr_lvl >= out_floor);
   // R17 Correction on AC units only
   wire ok_ctrl  = !hwdata[7] || ac_powered;
   // R4 Side low range
   wire ok_rx_in = (wpair.high >= `RXIN_MIN) && (wpair.high <= `RXIN_MAX)
                   && (wpair.low >= `RXIN_MIN) && (wpair.low <= `RXIN_MAX);
   // R20 Error on reject
   wire [3:0] nxt_err = sel_cur_a ? {3'h0, !ok_cur} : sel_cur_b ? {3'h0, !ok_cur} :
                        (sel_volt_a || sel_volt_b) ? {2'h0, !ok_volt, 1'b0} :
                        sel_in_low ? {1'b0, !ok_rx_in, 2'h0} : sel_in_lim ? {1'b0, !ok_in, 2'h0} :
                        sel_out ? {!ok_out, 3'h0} : sel_burst ? {!ok_burst, 3'h0} :
                        sel_ctrl ? {!ok_ctrl, 3'h0} : 4'h0;
   ////////////////////////////////////////////////////////////////////////
   // R2 Current ordering check
   limit_check u_cur (
      .pair  (wpair),
      .min_v (`CUR_MIN),
      .max_v (`CUR_MAX),
      .ok    (ok_cur)
   );
   // R7 Volt ordering check
   limit_check u_volt (
      .pair  (wpair),
      .min_v (`VOLT_MIN),
      .max_v (`VOLT_MAX),
      .ok    (ok_volt)
   );
   // R12 Input range check
   limit_check u_in (
      .pair  (wpair),
      .min_v (`TXIN_MIN),
      .max_v (`TXIN_MAX),
      .ok    (ok_in)
   );
   // R10 Output ordering check
   limit_check u_out (
      .pair  (wpair),
      .min_v (wpair.high - `RATED_SPAN),
      .max_v (wpair.high),
      .ok    (ok_out)
   );
   burst_sampler u_burst (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .enable      (power_monitor_mode),
      .power_in    (output_power),
      .valid_level (burst_lvl_ff),
      .avg_count   (burst_n_ff),
      .reading_ff  (burst_reading),
      .done_ff     (burst_done)
   );
   ////////////////////////////////////////////////////////////////////////
   // Zero wait states; every transfer answers OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_ff <= '0;
      end else if (hready) begin
         aph_ff <= '{htrans: hsel ? htrans : 2'b00, hwrite: hwrite, haddr: haddr};
      end
   end
   // R1 R3 R19 Reset defaults
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_a_ff <= '{high: `CUR_A_HIGH_RST, low: `CUR_A_LOW_RST};
         cur_b_ff <= '{high: `CUR_B_HIGH_RST, low: `CUR_B_LOW_RST};
         volt_a_ff <= '{high: `VOLT_HIGH_RST, low: `VOLT_LOW_RST};
         volt_b_ff <= '{high: `VOLT_HIGH_RST, low: `VOLT_LOW_RST};
         in_low_ff <= '{high: `RXIN_B_RST, low: `RXIN_A_RST};
         in_lim_ff <= '{high: `TXIN_HIGH_RST, low: `TXIN_LOW_RST};
         out_lim_ff <= '{high: `OUT_HIGH_RST, low: `OUT_LOW_RST};
         burst_lvl_ff <= `BURST_LVL_RST;
         burst_n_ff <= `BURST_N_RST;
         ctrl_ff <= `CTRL_RST;
         suppression_mask_ff <= `MASK_RST;
         err_ff <= 4'h0;
      end else begin
         // R20 Keep value on reject
         if (wr_phase) begin
            err_ff <= nxt_err;
         end
         if (sel_cur_a && ok_cur) begin
            cur_a_ff <= wpair;
         end
         if (sel_cur_b && ok_cur) begin
            cur_b_ff <= wpair;
         end
         if (sel_volt_a && ok_volt) begin
            volt_a_ff <= wpair;
         end
         if (sel_volt_b && ok_volt) begin
            volt_b_ff <= wpair;
         end
         // R4 Per-side low limit
         if (sel_in_low && ok_rx_in) begin
            in_low_ff <= wpair;
         end
         if (sel_in_lim && ok_in) begin
            in_lim_ff <= wpair;
         end
         if (sel_out && ok_out) begin
            out_lim_ff <= wpair;
         end
         if (sel_burst && ok_burst) begin
            burst_lvl_ff <= wr_lvl;
            burst_n_ff <= wr_n;
         end
         if (sel_ctrl && ok_ctrl) begin
            ctrl_ff <= hwdata[15:0] & `CTRL_MASK;
         end
         if (sel_mask) begin
            suppression_mask_ff <= hwdata[15:0];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // R16 Clamp temperature report
   wire signed [15:0] temp_clamped = (temperature < `TEMP_MIN) ? `TEMP_MIN :
                                     (temperature > `TEMP_MAX) ? `TEMP_MAX : temperature;
   // R18 Continuous or burst reading
   wire signed [15:0] nxt_power = power_monitor_mode ? (burst_done ? burst_reading : power_ff)
                                                     : output_power;
   wire        any_supp   = side_a_rx_suppress || side_b_rx_suppress || tx_power_suppress;
   // R6 Masked alarms dropped while any suppress bit is set
   wire [15:0] live       = alarm_sources & ~(any_supp ? suppression_mask_ff : 16'h0000);
   // R5 R11 Simulated alarms
   wire [7:0]  nxt_alarm  = {5'h00, tx_alarm_simulate, side_b_rx_alarm_simulate, side_a_rx_alarm_simulate};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         power_ff <= 16'h0000;
         temp_ff <= 16'h0000;
         side_a_relay_fault <= 1'b0;
         side_b_relay_fault <= 1'b0;
         major_alarm <= 1'b0;
         lamp_drive <= 1'b0;
         link_protocol_select <= 1'b0;
         mains_scaling_correction <= 1'b0;
         alarm_byte <= 8'h00;
      end else begin
         power_ff <= nxt_power;
         temp_ff <= temp_clamped;
         side_a_relay_fault <= side_a_rx_alarm_simulate;
         side_b_relay_fault <= side_b_rx_alarm_simulate;
         major_alarm <= (|live) || (|nxt_alarm);
         // R9 Lamp enable gate
         lamp_drive <= lamp_enable;
         // R8 Protocol select bit
         // Own bit, so a DC unit can still pick the binary format.
         link_protocol_select <= ctrl_ff[9];
         mains_scaling_correction <= ctrl_ff[7] && ac_powered;
         alarm_byte <= nxt_alarm;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      hrdata = 32'h00000000;
      if (aph_ff.haddr == `OFS_CUR_A) hrdata = cur_a_ff;
      else if (aph_ff.haddr == `OFS_CUR_B) hrdata = cur_b_ff;
      else if (aph_ff.haddr == `OFS_VOLT_A) hrdata = volt_a_ff;
      else if (aph_ff.haddr == `OFS_VOLT_B) hrdata = volt_b_ff;
      else if (aph_ff.haddr == `OFS_IN_LOW) hrdata = in_low_ff;
      else if (aph_ff.haddr == `OFS_IN_LIM) hrdata = in_lim_ff;
      else if (aph_ff.haddr == `OFS_OUT_LIM) hrdata = out_lim_ff;
      else if (aph_ff.haddr == `OFS_BURST_CFG) hrdata = {11'h000, burst_n_ff, burst_lvl_ff};
      else if (aph_ff.haddr == `OFS_CTRL) hrdata = {16'h0000, ctrl_ff};
      else if (aph_ff.haddr == `OFS_MASK) hrdata = {16'h0000, suppression_mask_ff};
      else if (aph_ff.haddr == `OFS_STATUS) hrdata = {8'h00, alarm_byte, live};
      else if (aph_ff.haddr == `OFS_POWER) hrdata = {16'h0000, power_ff};
      else if (aph_ff.haddr == `OFS_TEMP) hrdata = {16'h0000, temp_ff};
      else if (aph_ff.haddr == `OFS_ERR) hrdata = {28'h0000000, err_ff};
   end
   ////////////////////////////////////////////////////////////////////////
   AST_CUR_ORDER: assert property (@(posedge hclk) disable iff (!hresetn) // R2
      cur_a_ff.low < cur_a_ff.high && cur_b_ff.low < cur_b_ff.high)
      else $error("Current limits out of order.");
   AST_CUR_A_RANGE: assert property (@(posedge hclk) disable iff (!hresetn) // R1
      cur_a_ff.low >= `CUR_MIN && cur_a_ff.low <= `CUR_MAX)
      else $error("Side A low current out of range.");
   AST_CUR_B_RANGE: assert property (@(posedge hclk) disable iff (!hresetn) // R3
      cur_b_ff.high >= `CUR_MIN && cur_b_ff.high <= `CUR_MAX)
      else $error("Side B high current out of range.");
   AST_VOLT_ORDER: assert property (@(posedge hclk) disable iff (!hresetn) // R7
      volt_a_ff.low < volt_a_ff.high && volt_a_ff.high <= `VOLT_MAX)
      else $error("Side A volt limits invalid.");
   AST_REJECT_KEEP: assert property (@(posedge hclk) disable iff (!hresetn) // R20
      (sel_cur_a && !ok_cur) |=> ($stable(cur_a_ff) && err_ff[0]))
      else $error("Rejected write changed stored value.");
   AST_RX_SIM: assert property (@(posedge hclk) disable iff (!hresetn) // R5
      side_a_rx_alarm_simulate |=> (side_a_relay_fault && alarm_byte[0]))
      else $error("Rx simulation did not fault relay.");
   AST_TX_SIM: assert property (@(posedge hclk) disable iff (!hresetn) // R11
      !tx_alarm_simulate |=> !alarm_byte[2])
      else $error("Tx alarm raised without simulation.");
   AST_LAMP_DARK: assert property (@(posedge hclk) disable iff (!hresetn) // R9
      !lamp_enable |=> !lamp_drive)
      else $error("Lamp lit while disabled.");
   AST_DC_NO_CORR: assert property (@(posedge hclk) disable iff (!hresetn) // R17
      !ac_powered |=> !mains_scaling_correction)
      else $error("Mains correction on a DC unit.");
   AST_TEMP_RANGE: assert property (@(posedge hclk) disable iff (!hresetn) // R16
      temp_ff >= `TEMP_MIN && temp_ff <= `TEMP_MAX)
      else $error("Temperature report out of range.");
endmodule // alarm_threshold_burst_monitor

//--- dv/alarm_field_model.sv
// Purpose: Field side that raises alarm sources and output power.
// Assumes: One clock, levels change after a rising edge.
// Notes: The power level follows the bench; it feeds the monitor only.
`timescale 1ns/1ps
module alarm_field_model (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic [15:0]        raise,
   input  wire logic signed [15:0] level,
   output logic [15:0]             alarm_sources_ff,
   output wire logic signed [15:0] output_power
);
   assign output_power = level;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alarm_sources_ff <= 16'h0000;
      end else begin
         alarm_sources_ff <= raise;
      end
   end
endmodule // alarm_field_model

//--- dv/alarm_threshold_burst_monitor_tb.sv
// Purpose: Register, limit and alarm checks of the threshold monitor.
// Assumes: Slave answers at once, but the master still waits for ready.
// Notes: The sixteen-sample burst takes too long for this run and is left out.
`timescale 1ns/1ps
`include "threshold_monitor_params.svh"
module alarm_threshold_burst_monitor_tb import threshold_monitor_pkg::*;;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ac_pw = 0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic [15:0] raise = 16'h0, alarm_sources;
   logic signed [15:0] output_power, lvl = 16'sd200, tin = -16'sd70;
   wire hready, hresp, ra, rb, major, lamp, proto, mains;
   wire [7:0] abyte;
   int fail_count = 0, cmp_count = 0;
   logic [11:0] ofs [9];
   logic [31:0] expv [9];
   always #10 hclk = ~hclk;
   alarm_field_model u_fld (.hclk(hclk), .hresetn(hresetn), .raise(raise), .level(lvl),
      .alarm_sources_ff(alarm_sources), .output_power(output_power));
   alarm_threshold_burst_monitor u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .ac_powered(ac_pw), .output_power(output_power),
      .temperature(tin), .alarm_sources(alarm_sources), .side_a_relay_fault(ra),
      .side_b_relay_fault(rb), .major_alarm(major), .lamp_drive(lamp), .link_protocol_select(proto),
      .mains_scaling_correction(mains), .alarm_byte(abyte));
   ////////////////////////////////////////////////////////////////////////////
   task end_of_test;
      if (fail_count == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Ready and read data are taken at the rising edge, before that edge's updates land.
   task wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) begin
            fail_count++;
            $display("CHECK FAILED at %0t: ready timeout", $time);
            end_of_test;
         end
         @(posedge hclk);
      end
      rd = hrdata;
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
      wait_ready;
      htrans <= 2'b00; hsel <= 1'b0; hwdata <= d;
      wait_ready;
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   function automatic logic [31:0] pk(input logic [15:0] h, input logic [15:0] l);
      return {h, l};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      ofs = '{`OFS_CUR_A, `OFS_CUR_B, `OFS_VOLT_A, `OFS_VOLT_B, `OFS_IN_LOW, `OFS_IN_LIM, `OFS_OUT_LIM,
              `OFS_BURST_CFG, `OFS_MASK};
      expv = '{pk(`CUR_A_HIGH_RST, `CUR_A_LOW_RST), pk(`CUR_B_HIGH_RST, `CUR_B_LOW_RST),
               pk(`VOLT_HIGH_RST, `VOLT_LOW_RST), pk(`VOLT_HIGH_RST, `VOLT_LOW_RST), pk(`RXIN_B_RST, `RXIN_A_RST),
               pk(`TXIN_HIGH_RST, `TXIN_LOW_RST), pk(`OUT_HIGH_RST, `OUT_LOW_RST),
               {11'h0, `BURST_N_RST, `BURST_LVL_RST}, {16'h0, `MASK_RST}};
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 9; i++) rdchk(ofs[i], expv[i]);
      chk({lamp, ra, rb, major, mains, hresp, hready}, 7'b1000001);
      rdchk(`OFS_TEMP, {16'h0, `TEMP_MIN});
      rdchk(`OFS_POWER, {16'h0, 16'sd200});
      xfer(1'b1, `OFS_CUR_A, pk(16'sd500, 16'sd500));
      rdchk(`OFS_CUR_A, pk(`CUR_A_HIGH_RST, `CUR_A_LOW_RST));
      rdchk(`OFS_ERR, 32'h1);
      xfer(1'b1, `OFS_CUR_B, pk(16'sd601, 16'sd100));
      rdchk(`OFS_CUR_B, pk(`CUR_B_HIGH_RST, `CUR_B_LOW_RST));
      xfer(1'b1, `OFS_CUR_A, pk(16'sd600, 16'sd100));
      rdchk(`OFS_CUR_A, pk(16'sd600, 16'sd100));
      xfer(1'b1, `OFS_VOLT_A, pk(16'sd251, 16'sd150));
      rdchk(`OFS_VOLT_A, pk(`VOLT_HIGH_RST, `VOLT_LOW_RST));
      xfer(1'b1, `OFS_IN_LIM, pk(-16'sd600, -16'sd150));
      rdchk(`OFS_IN_LIM, pk(`TXIN_HIGH_RST, `TXIN_LOW_RST));
      xfer(1'b1, `OFS_OUT_LIM, pk(16'sd340, 16'sd139));
      rdchk(`OFS_OUT_LIM, pk(`OUT_HIGH_RST, `OUT_LOW_RST));
      xfer(1'b1, `OFS_IN_LOW, pk(-16'sd100, 16'sd50));
      rdchk(`OFS_IN_LOW, pk(-16'sd100, 16'sd50));
      rdchk(`OFS_ERR, 32'h0);
      xfer(1'b1, `OFS_BURST_CFG, {11'h0, 5'd0, 16'sd200});
      rdchk(`OFS_ERR, 32'h8);
      xfer(1'b1, `OFS_BURST_CFG, {11'h0, 5'd16, 16'sd200});
      rdchk(`OFS_BURST_CFG, {11'h0, 5'd16, 16'sd200});
      xfer(1'b1, 12'h0fc, 32'hffff_ffff);
      rdchk(`OFS_CUR_A, pk(16'sd600, 16'sd100));
      xfer(1'b1, `OFS_CTRL, 32'h0000_00c0);
      repeat (3) @(posedge hclk);
      chk({mains, lamp}, 2'b01);
      ac_pw <= 1'b1;
      xfer(1'b1, `OFS_CTRL, 32'h0000_0280);
      repeat (3) @(posedge hclk);
      chk({mains, lamp, proto}, 3'b101);
      xfer(1'b1, `OFS_CTRL, 32'h0000_0013);
      repeat (3) @(posedge hclk);
      chk({ra, rb, abyte, major}, {2'b11, 8'h07, 1'b1});
      raise <= 16'h0008;
      xfer(1'b1, `OFS_CTRL, 32'h0000_0044);
      repeat (3) @(posedge hclk);
      chk({ra, abyte, major, lamp}, {1'b0, 8'h00, 1'b0, 1'b1});
      raise <= 16'h0001;
      repeat (3) @(posedge hclk);
      chk(major, 1'b1);
      xfer(1'b1, `OFS_CTRL, 32'h0000_0040);
      raise <= 16'h0008;
      repeat (3) @(posedge hclk);
      chk(major, 1'b1);
      rdchk(`OFS_STATUS, {16'h0, 16'h0008});
      xfer(1'b1, `OFS_CTRL, 32'h0000_0140);
      lvl <= 16'sd150;
      tin <= 16'sd120;
      rdchk(`OFS_POWER, {16'h0, 16'sd200});
      xfer(1'b1, `OFS_CTRL, 32'h0000_0040);
      rdchk(`OFS_POWER, {16'h0, 16'sd150});
      rdchk(`OFS_TEMP, {16'h0, `TEMP_MAX});
      end_of_test;
   end
endmodule // alarm_threshold_burst_monitor_tb
